// >>> src/xped_cfg_reg.sv
// lockable 16-bit configuration register with registered read data
`timescale 1ns/1ps
module xped_cfg_reg #(
    parameter int          WIDTH = 16,
    parameter logic [15:0] RVAL  = 16'h0005,
    parameter logic [15:0] WMASK = 16'h07FF
) (
    input  wire logic             mclk_i,  // clock
    input  wire logic             rstn_i,  // async reset, low
    input  wire logic             we_i,    // write strobe
    input  wire logic             lock_i,  // writes ignored when high
    input  wire logic [WIDTH-1:0] wdata_i, // write data
    output logic      [WIDTH-1:0] q_o      // stored value
);
    // refused at elaboration, reset and mask constants are 16 bits wide
    if (WIDTH != 16) begin : g_width_check
        $error("xped_cfg_reg: WIDTH must be 16");
    end

    typedef struct packed {
        logic [WIDTH-1:0] val;
    } xped_cr_state_t;

    xped_cr_state_t st_reg;
    xped_cr_state_t st_next;

    always_comb begin
        st_next = st_reg;
        // reserved bits never stored, so they read as zero
        if (we_i && !lock_i) begin
            st_next.val = wdata_i & WMASK;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg.val <= RVAL;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_o = st_reg.val;
endmodule

// >>> src/xped_pkg.sv
// constants for the peripheral enable and address decode block
package xped_pkg;
    localparam int          NUM_EN              = 11;
    localparam logic [15:0] CFG_ADDR            = 16'hF024;
    localparam logic [15:0] MIRROR_ADDR         = 16'hEB7E;
    localparam logic [15:0] CFG_RESET           = 16'h0005;
    localparam logic [15:0] CFG_WR_MASK         = 16'h07FF;
    localparam logic [15:0] EMU_MASK            = 16'h07D3;
    // bit positions inside the enable configuration
    localparam int          B_CAN1              = 0;
    localparam int          B_CAN2              = 1;
    localparam int          B_SRAM              = 2;
    localparam int          B_LRAM              = 3;
    localparam int          B_RTC               = 4;
    localparam int          B_FLASH             = 5;
    localparam int          B_PWM               = 6;
    localparam int          B_ASC               = 7;
    localparam int          B_SSC               = 8;
    localparam int          B_I2C               = 9;
    localparam int          B_MISC              = 10;
    // address windows, 24-bit
    localparam logic [23:0] SRAM_LO             = 24'h00_E000;
    localparam logic [23:0] SRAM_HI             = 24'h00_E7FF;
    localparam logic [23:0] SHR_LO              = 24'h00_E800;
    localparam logic [23:0] SHR_HI              = 24'h00_EFFF;
    localparam logic [23:0] SSC_LO              = 24'h00_E800;
    localparam logic [23:0] SSC_HI              = 24'h00_E8FF;
    localparam logic [23:0] ASC_LO              = 24'h00_E900;
    localparam logic [23:0] ASC_HI              = 24'h00_E9FF;
    localparam logic [23:0] I2C_LO              = 24'h00_EA00;
    localparam logic [23:0] I2C_HI              = 24'h00_EAFF;
    localparam logic [23:0] MISC_LO             = 24'h00_EB00;
    localparam logic [23:0] MISC_HI             = 24'h00_EBFF;
    localparam logic [23:0] PWM_LO              = 24'h00_EC00;
    localparam logic [23:0] PWM_HI              = 24'h00_ECFF;
    localparam logic [23:0] RTC_LO              = 24'h00_ED00;
    localparam logic [23:0] RTC_HI              = 24'h00_EDFF;
    localparam logic [23:0] CAN_LO              = 24'h00_EC00;
    localparam logic [23:0] CAN_HI              = 24'h00_EFFF;
    localparam logic [23:0] FLASH_LO            = 24'h09_0000;
    localparam logic [23:0] FLASH_HI            = 24'h0E_FFFF;
    localparam logic [23:0] LRAM_LO             = 24'h0F_0000;
    localparam logic [23:0] LRAM_HI             = 24'h0F_FFFF;
    localparam logic [7:0]  SEG8                = 8'h08;
    // route codes
    typedef enum logic [1:0] {
        XPED_RT_NONE = 2'b00,
        XPED_RT_INT  = 2'b01,
        XPED_RT_EXT  = 2'b10,
        XPED_RT_RSV  = 2'b11
    } xped_route_t;
endpackage

// >>> src/xped_top.sv
// peripheral enable configuration and address routing decode
// Behaviour
// - first CAN off; shared range external if all off
// - second CAN off; same shared range condition
// - small RAM off routes E000-E7FF external
// - large RAM off; F0000 external if flash off
// - clock calendar off; ED00 range shared condition
// - pulse width off; EC00-ECFF shared condition
// - flash off; 90000-EFFFF external if large off
// - async serial off; E900 range shared condition
// - sync serial off; E800 range shared condition
// - two wire off; EA00 range shared condition
// - misc off; EB00 range shared condition
// - all shared off: E800-EFFF to external bus
// - disabled module pins freed for general I/O
// - reset value 005h: first CAN, small RAM
// - writes ignored once global enable set
// - emulation mode: all enables read as set
// - segment 8 mapping by pin and enables
// - write-only mirror at EB7E, same bits
// - config register F024 read/write, bits 0-10
`timescale 1ns/1ps
module xped_top #(
    parameter int ADDR_W = 24
) (
    input  wire logic              mclk_i,          // cpu clock
    input  wire logic              rstn_i,          // async reset, low
    input  wire logic [15:0]       reg_addr_i,      // register address
    input  wire logic              reg_wr_i,        // register write strobe
    input  wire logic              reg_rd_i,        // register read strobe
    input  wire logic [15:0]       reg_wdata_i,     // write data
    output logic      [15:0]       reg_rdata_o,     // read data
    output logic                   reg_rvalid_o,    // read data valid
    input  wire logic              xperiph_en_i,    // global enable from system config
    input  wire logic              emu_mode_i,      // emulation mode
    input  wire logic              ext_access_i,    // external access pin level
    input  wire logic              acc_req_i,       // cpu access request
    input  wire logic [ADDR_W-1:0] acc_addr_i,      // cpu access address
    output logic                   acc_valid_o,     // routing result valid
    output logic      [1:0]        acc_route_o,     // route code
    output logic      [10:0]       mod_sel_o,       // one-hot module select
    output logic                   flash_sel_o,     // internal segment 8 flash
    output logic      [10:0]       mod_en_o,        // effective enables
    output logic      [10:0]       pin_gpio_o,      // module pins free as gpio
    output logic      [15:0]       mirror_o,        // emulation mirror contents
    output logic                   mirror_wr_o      // mirror written pulse
);
    // windows are 24-bit constants, other widths refused at elaboration
    if (ADDR_W != 24) begin : g_addr_w_check
        $error("xped_top: ADDR_W must be 24");
    end

    typedef struct packed {
        logic [15:0] rdata;
        logic        rvalid;
        logic        valid;
        logic [1:0]  route;
        logic [10:0] sel;
        logic        flash;
        logic [10:0] en;
        logic [10:0] gpio;
        logic [15:0] mirror;
        logic        mwr;
    } xped_state_t;

    xped_state_t st_reg;
    xped_state_t st_next;
    logic [15:0] cfg_q;
    logic        cfg_we;

    assign cfg_we = reg_wr_i && (reg_addr_i == xped_pkg::CFG_ADDR);

    xped_cfg_reg #(
        .WIDTH (16),
        .RVAL  (xped_pkg::CFG_RESET),
        .WMASK (xped_pkg::CFG_WR_MASK)
    ) u_cfg (
        .mclk_i  (mclk_i),
        .rstn_i  (rstn_i),
        .we_i    (cfg_we),
        .lock_i  (xperiph_en_i),
        .wdata_i (reg_wdata_i),
        .q_o     (cfg_q)
    );

    function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    always_comb begin
        logic [10:0] en;
        logic        shr_any;
        logic [23:0] a;
        logic        hit;
        en      = 11'h000;
        shr_any = 1'b0;
        a       = acc_addr_i;
        hit     = 1'b0;
        st_next = st_reg;

        en = emu_mode_i ? {11{1'b1}} : cfg_q[10:0];

        shr_any = en[xped_pkg::B_CAN1] | en[xped_pkg::B_CAN2] | en[xped_pkg::B_RTC]
                | en[xped_pkg::B_PWM] | en[xped_pkg::B_ASC] | en[xped_pkg::B_SSC]
                | en[xped_pkg::B_I2C] | en[xped_pkg::B_MISC];

        st_next.en   = en;
        st_next.gpio = ~en;

        // register read path, unmapped and write-only read as zero
        st_next.rvalid = reg_rd_i;
        st_next.rdata  = 16'h0000;
        if (reg_rd_i && reg_addr_i == xped_pkg::CFG_ADDR) begin
            st_next.rdata = emu_mode_i ? xped_pkg::CFG_WR_MASK : cfg_q;
        end

        st_next.mwr = reg_wr_i && (reg_addr_i == xped_pkg::MIRROR_ADDR);
        if (st_next.mwr) begin
            st_next.mirror = reg_wdata_i & xped_pkg::CFG_WR_MASK;
        end

        st_next.valid = acc_req_i;
        st_next.route = xped_pkg::XPED_RT_NONE;
        st_next.sel   = 11'h000;
        st_next.flash = 1'b0;
        if (acc_req_i) begin
            st_next.route = xped_pkg::XPED_RT_EXT;
            if (in_rng(a, xped_pkg::SRAM_LO, xped_pkg::SRAM_HI)
                && en[xped_pkg::B_SRAM]) begin
                st_next.sel[xped_pkg::B_SRAM] = 1'b1;
                hit = 1'b1;
            end
            if (in_rng(a, xped_pkg::SSC_LO, xped_pkg::SSC_HI) && en[xped_pkg::B_SSC]) begin
                st_next.sel[xped_pkg::B_SSC] = 1'b1;
                hit = 1'b1;
            end
            if (in_rng(a, xped_pkg::ASC_LO, xped_pkg::ASC_HI) && en[xped_pkg::B_ASC]) begin
                st_next.sel[xped_pkg::B_ASC] = 1'b1;
                hit = 1'b1;
            end
            if (in_rng(a, xped_pkg::I2C_LO, xped_pkg::I2C_HI) && en[xped_pkg::B_I2C]) begin
                st_next.sel[xped_pkg::B_I2C] = 1'b1;
                hit = 1'b1;
            end
            if (in_rng(a, xped_pkg::MISC_LO, xped_pkg::MISC_HI)
                && en[xped_pkg::B_MISC]) begin
                st_next.sel[xped_pkg::B_MISC] = 1'b1;
                hit = 1'b1;
            end
            if (in_rng(a, xped_pkg::PWM_LO, xped_pkg::PWM_HI) && en[xped_pkg::B_PWM]) begin
                st_next.sel[xped_pkg::B_PWM] = 1'b1;
                hit = 1'b1;
            end
            if (in_rng(a, xped_pkg::RTC_LO, xped_pkg::RTC_HI) && en[xped_pkg::B_RTC]) begin
                st_next.sel[xped_pkg::B_RTC] = 1'b1;
                hit = 1'b1;
            end
            // first CAN wins over second CAN; both share the upper window
            if (in_rng(a, xped_pkg::CAN_LO, xped_pkg::CAN_HI) && !hit) begin
                st_next.sel[xped_pkg::B_CAN1] = en[xped_pkg::B_CAN1];
                st_next.sel[xped_pkg::B_CAN2] = en[xped_pkg::B_CAN2]
                                              & ~en[xped_pkg::B_CAN1];
                hit = en[xped_pkg::B_CAN1] | en[xped_pkg::B_CAN2];
            end
            // shared window goes external only when all off
            if (in_rng(a, xped_pkg::SHR_LO, xped_pkg::SHR_HI) && !hit && shr_any) begin
                st_next.route = xped_pkg::XPED_RT_NONE;
            end
            if (in_rng(a, xped_pkg::FLASH_LO, xped_pkg::FLASH_HI)) begin
                if (en[xped_pkg::B_FLASH]) begin
                    st_next.sel[xped_pkg::B_FLASH] = 1'b1;
                    hit = 1'b1;
                end else if (en[xped_pkg::B_LRAM]) begin
                    st_next.route = xped_pkg::XPED_RT_NONE;
                end
            end
            if (in_rng(a, xped_pkg::LRAM_LO, xped_pkg::LRAM_HI)) begin
                if (en[xped_pkg::B_LRAM]) begin
                    st_next.sel[xped_pkg::B_LRAM] = 1'b1;
                    hit = 1'b1;
                end else if (en[xped_pkg::B_FLASH]) begin
                    st_next.route = xped_pkg::XPED_RT_NONE;
                end
            end
            if (a[23:16] == xped_pkg::SEG8) begin
                if (ext_access_i) begin
                    st_next.flash = 1'b1;
                    hit = 1'b1;
                end else if (xperiph_en_i && (en[xped_pkg::B_LRAM]
                                              | en[xped_pkg::B_FLASH])) begin
                    st_next.route = xped_pkg::XPED_RT_RSV;
                end
            end
            if (hit) begin
                st_next.route = xped_pkg::XPED_RT_INT;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_reg.rdata  <= 16'h0000;
            st_reg.rvalid <= 1'b0;
            st_reg.valid  <= 1'b0;
            st_reg.route  <= 2'b00;
            st_reg.sel    <= 11'h000;
            st_reg.flash  <= 1'b0;
            st_reg.en     <= xped_pkg::CFG_RESET[10:0];
            st_reg.gpio   <= ~xped_pkg::CFG_RESET[10:0];
            st_reg.mirror <= 16'h0000;
            st_reg.mwr    <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o  = st_reg.rdata;
    assign reg_rvalid_o = st_reg.rvalid;
    assign acc_valid_o  = st_reg.valid;
    assign acc_route_o  = st_reg.route;
    assign mod_sel_o    = st_reg.sel;
    assign flash_sel_o  = st_reg.flash;
    assign mod_en_o     = st_reg.en;
    assign pin_gpio_o   = st_reg.gpio;
    assign mirror_o     = st_reg.mirror;
    assign mirror_wr_o  = st_reg.mwr;
endmodule

// >>> tb/tb_xperipheral_enable_decode.sv
// self-checking bench for the peripheral enable decode
`timescale 1ns/1ps
module tb_xperipheral_enable_decode;
    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        glb_en = 1'b0;
    logic        emu    = 1'b0;
    logic        extpin = 1'b0;
    logic        rw, rr, areq, rvalid, avalid, fsel, mwr, xp;
    logic [15:0] raddr, wdata, rdata, mirror, cfg;
    logic [23:0] aaddr;
    logic [1:0]  route;
    logic [10:0] msel, men, gpio;
    logic [15:0] rdq[$];
    logic [13:0] acq[$];
    int          error_cnt = 0;
    int          n_checks  = 0;
    logic [23:0] addr_tab[12] = '{24'h00_E3F0, 24'h00_E8AA, 24'h00_E901, 24'h00_EA10,
        24'h00_EBFF, 24'h00_EC40, 24'h00_ED20, 24'h00_EE00, 24'h00_EFFE, 24'h0A_1234,
        24'h0F_8000, 24'h08_ABCD};
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    xped_cpu_model cpu (.mclk_i(mclk_i), .reg_wr_o(rw), .reg_rd_o(rr), .reg_addr_o(raddr),
        .reg_wdata_o(wdata), .acc_req_o(areq), .acc_addr_o(aaddr));
    xped_top uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(raddr), .reg_wr_i(rw),
        .reg_rd_i(rr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .xperiph_en_i(glb_en), .emu_mode_i(emu), .ext_access_i(extpin), .acc_req_i(areq),
        .acc_addr_i(aaddr), .acc_valid_o(avalid), .acc_route_o(route), .mod_sel_o(msel),
        .flash_sel_o(fsel), .mod_en_o(men), .pin_gpio_o(gpio), .mirror_o(mirror),
        .mirror_wr_o(mwr));
    task automatic chk(input logic [15:0] e, input logic [15:0] a);
        n_checks++;
        if (a !== e) begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic rd_exp(input logic [15:0] a, input logic [15:0] e);
        rdq.push_back(e);
        cpu.rd(a);
    endtask
    // expected route, select and flash flag from the enables
    function automatic logic [13:0] exp_acc(logic [10:0] e, logic [23:0] a, logic p, logic x);
        logic [1:0]  r;
        logic [10:0] s;
        logic        f;
        r = 2'd2;
        s = '0;
        f = 1'b0;
        if (a[23:16] == 8'h08) begin
            f = p;
            r = p ? 2'd1 : ((!x || !(e[3] | e[5])) ? 2'd2 : 2'd3);
        end else if (a <= 24'h00_E7FF) begin
            s[2] = e[2];
            r = e[2] ? 2'd1 : 2'd2;
        end else if (a <= 24'h00_EFFF) begin
            case (a[11:8])
                4'h8: s[8] = e[8];
                4'h9: s[7] = e[7];
                4'hA: s[9] = e[9];
                4'hB: s[10] = e[10];
                4'hC: s[6] = e[6];
                4'hD: s[4] = e[4];
                default: ;
            endcase
            if (s == 11'h000 && a[11:10] == 2'b11)
                s = e[0] ? 11'h001 : (e[1] ? 11'h002 : 11'h000);
            r = ((e & 11'h7D3) == 11'h000) ? 2'd2 : ((s != 11'h000) ? 2'd1 : 2'd0);
        end else begin
            s[5] = (a[19:16] != 4'hF) & e[5];
            s[3] = (a[19:16] == 4'hF) & e[3];
            r = (s != 11'h000) ? 2'd1 : ((a[19:16] == 4'hF ? e[5] : e[3]) ? 2'd0 : 2'd2);
        end
        return {r, s, f};
    endfunction
    always @(posedge mclk_i) begin
        if (rvalid === 1'b1) chk(rdq.pop_front(), rdata);
        if (avalid === 1'b1) chk({2'd0, acq.pop_front()}, {2'd0, route, msel, fsel});
    end
    initial begin
        #50000;
        error_cnt++;
        complete_run();
    end
    initial begin
        void'($urandom(2));
        repeat (10) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        chk(16'h0005, {5'd0, men});
        chk(16'h07FA, {5'd0, gpio});
        rd_exp(xped_pkg::CFG_ADDR, 16'h0005);
        for (int i = 0; i < 40; i++) begin
            cfg = (i == 0) ? 16'h0000 : ((i == 1) ? 16'h07FF : 16'($urandom()) & 16'h07FF);
            xp = 1'($urandom());
            @(posedge mclk_i);
            glb_en <= 1'b0;
            extpin <= 1'($urandom());
            cpu.wr(xped_pkg::CFG_ADDR, cfg);
            glb_en <= xp;
            rd_exp(xped_pkg::CFG_ADDR, cfg);
            #1;
            chk(cfg, {5'd0, men});
            chk(~cfg & 16'h07FF, {5'd0, gpio});
            foreach (addr_tab[j]) begin
                acq.push_back(exp_acc(cfg[10:0], addr_tab[j],
                                      extpin, xp));
                cpu.acc(addr_tab[j]);
            end
            if (xp) begin
                cpu.wr(xped_pkg::CFG_ADDR, ~cfg);
                rd_exp(xped_pkg::CFG_ADDR, cfg);
                if ((cfg & xped_pkg::EMU_MASK) != 16'h0000) begin
                    cpu.wr(xped_pkg::MIRROR_ADDR, cfg);
                    #1;
                    chk(16'h0001, {15'd0, mwr});
                    chk(cfg, mirror);
                    rd_exp(xped_pkg::MIRROR_ADDR, 16'h0000);
                end
            end
        end
        @(posedge mclk_i);
        // mid-run reset must bring back the default enables
        rstn_i <= 1'b0;
        glb_en <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        chk(xped_pkg::CFG_RESET, {5'd0, men});
        chk(~xped_pkg::CFG_RESET & 16'h07FF, {5'd0, gpio});
        rd_exp(xped_pkg::CFG_ADDR, xped_pkg::CFG_RESET);
        @(posedge mclk_i);
        glb_en <= 1'b0;
        emu    <= 1'b1;
        repeat (3) @(posedge mclk_i);
        #1;
        chk(16'h07FF, {5'd0, men});
        rd_exp(xped_pkg::CFG_ADDR, 16'h07FF);
        rd_exp(16'h1234, 16'h0000);
        repeat (3) @(posedge mclk_i);
        complete_run();
    end
endmodule

// >>> tb/xped_cpu_model.sv
// cpu side bus master model for register and access requests
`timescale 1ns/1ps
module xped_cpu_model (
    input  wire logic        mclk_i,      // clock
    output logic             reg_wr_o,    // write strobe
    output logic             reg_rd_o,    // read strobe
    output logic      [15:0] reg_addr_o,  // register address
    output logic      [15:0] reg_wdata_o, // write data
    output logic             acc_req_o,   // access request
    output logic      [23:0] acc_addr_o   // access address
);
    initial begin
        {reg_wr_o, reg_rd_o, acc_req_o} = 3'b000;
        {reg_addr_o, reg_wdata_o, acc_addr_o} = '0;
    end
    // released lines show the inverse, not the last value
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_wr_o    <= 1'b1;
        reg_addr_o  <= a;
        reg_wdata_o <= d & 16'h07FF;
        @(posedge mclk_i);
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge mclk_i);
        reg_rd_o   <= 1'b1;
        reg_addr_o <= a;
        @(posedge mclk_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
    endtask
    task automatic acc(input logic [23:0] a);
        @(posedge mclk_i);
        acc_req_o  <= 1'b1;
        acc_addr_o <= a;
        @(posedge mclk_i);
        acc_req_o  <= 1'b0;
        acc_addr_o <= ~a;
    endtask
endmodule

// >>> tb/xped_top_chk.sv
// assertion checker for the peripheral enable decode top
`timescale 1ns/1ps
module xped_top_chk #(
    parameter int ADDR_W = 24
) (
    input wire logic              mclk_i,       // clock
    input wire logic              rstn_i,       // reset, low
    input wire logic [15:0]       reg_addr_i,   // reg address
    input wire logic              reg_wr_i,     // write strobe
    input wire logic              reg_rd_i,     // read strobe
    input wire logic [15:0]       reg_wdata_i,  // write data
    input wire logic [15:0]       reg_rdata_o,  // read data
    input wire logic              reg_rvalid_o, // read valid
    input wire logic              xperiph_en_i, // global enable
    input wire logic              emu_mode_i,   // emulation
    input wire logic              ext_access_i, // access pin
    input wire logic              acc_req_i,    // access request
    input wire logic [ADDR_W-1:0] acc_addr_i,   // access address
    input wire logic              acc_valid_o,  // route valid
    input wire logic [1:0]        acc_route_o,  // route code
    input wire logic              flash_sel_o,  // flash select
    input wire logic [10:0]       mod_en_o,     // enables
    input wire logic [10:0]       pin_gpio_o,   // free pins
    input wire logic [15:0]       mirror_o,     // mirror
    input wire logic              mirror_wr_o   // mirror pulse
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_mirror_wr;
        reg_wr_i && reg_addr_i == xped_pkg::MIRROR_ADDR;
    endsequence
    sequence s_mirror_seen;
        mirror_wr_o && mirror_o == ($past(reg_wdata_i) & 16'h07FF);
    endsequence
    a_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    a_rd_quiet: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("read valid without read");
    a_rd_unmapped: assert property (reg_rd_i && reg_addr_i != xped_pkg::CFG_ADDR
        |=> reg_rdata_o == 16'h0000) else $error("non config read not zero");
    a_acc_answer: assert property (acc_req_i |=> acc_valid_o)
        else $error("access not routed");
    a_gpio_inverse: assert property (pin_gpio_o == ~mod_en_o)
        else $error("gpio pins not inverse of enables");
    a_emu_all_on: assert property (emu_mode_i [*2] |-> mod_en_o == 11'h7FF)
        else $error("emulation enables not all set");
    a_lock_hold: assert property ((xperiph_en_i && !emu_mode_i) [*3]
        |-> $stable(mod_en_o)) else $error("enables changed while locked");
    a_mirror_load: assert property (s_mirror_wr |=> s_mirror_seen)
        else $error("mirror not loaded");
    a_seg8_flash: assert property (acc_req_i && acc_addr_i[23:16] == 8'h08
        && ext_access_i |=> acc_route_o == xped_pkg::XPED_RT_INT && flash_sel_o)
        else $error("seg 8 not flash");
endmodule
bind xped_top xped_top_chk #(.ADDR_W(ADDR_W)) chk (.mclk_i, .rstn_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .xperiph_en_i, .emu_mode_i,
    .ext_access_i, .acc_req_i, .acc_addr_i, .acc_valid_o, .acc_route_o, .flash_sel_o,
    .mod_en_o, .pin_gpio_o, .mirror_o, .mirror_wr_o);
